// File: rtl/tcw_regs.svh
/*
 Offsets, field positions and reset values of the timer channel.
 Assumes byte offsets on an 8-bit register port, one 32-bit word each.
*/
// How it works
// - Stop field set: a C match in waveform mode stops the counter clock until retriggered.
// - Disable field set: a C match in waveform mode disables the counter clock.
// - Event edge field picks none, rising, falling or both edges.
// - Event source field picks line B or external clock 0, 1, 2.
// - With line B as event source it is an input without waveform flags.
// - Event trigger enable: an event resets the counter and starts its clock.
// - In waveform mode the shape field picks up or up/down counting, with or without C trigger.
// - Mode bit selects waveform generation (1) or capture (0).
// - A match, C match, event and soft trigger act on line A.
// - B match, C match, event and soft trigger act on line B.
// - Counter value register returns the live 16-bit count.
// - Registers A and B are writable only in waveform mode.
// - Register C is read/write in both modes.
// - Overflow flag sets on counter overflow, clears on status read.
// - Load overrun flag: capture reload before read, zero in waveform mode.
// - A and B match flags set only in waveform mode.
// - C match flag sets in both modes, clears on status read.
// - A and B load flags set only in capture mode.
// - External trigger flag sets on an event, clears on status read; reads zero in capture mode.
// - Status bit 16 shows whether the counter clock is enabled.
// - Status bits 17 and 18 mirror lines A and B.
`ifndef TCW_REGS_SVH
`define TCW_REGS_SVH

`define TCW_OFS_CTRL   8'h00
`define TCW_OFS_MODE   8'h04
`define TCW_OFS_CV     8'h10
`define TCW_OFS_RA     8'h14
`define TCW_OFS_RB     8'h18
`define TCW_OFS_RC     8'h1c
`define TCW_OFS_SR     8'h20

`define TCW_CTRL_EN    0
`define TCW_CTRL_DIS   1
`define TCW_CTRL_SWT   2

`define TCW_M_STOP     6
`define TCW_M_DIS      7
`define TCW_M_EDGE     8
`define TCW_M_SRC      10
`define TCW_M_ENTRG    12
`define TCW_M_SHAPE    13
`define TCW_M_WAVE     15
`define TCW_M_A_AM     16
`define TCW_M_A_CM     18
`define TCW_M_A_EV     20
`define TCW_M_A_SW     22
`define TCW_M_B_BM     24
`define TCW_M_B_CM     26
`define TCW_M_B_EV     28
`define TCW_M_B_SW     30

`define TCW_SR_CLKON   16
`define TCW_SR_MIR_A   17
`define TCW_SR_MIR_B   18

`define TCW_MODE_RST   32'h0000_0000
`define TCW_CNT_MAX    16'hffff

`endif

// File: rtl/tcw_pkg.sv
/*
 Types of the timer channel.
 Assumes nothing beyond the register header.
*/
package tcw_pkg;
	typedef enum logic [1:0] {
		TCW_UP   = 2'b01,
		TCW_DOWN = 2'b10
	} tcw_dir_t;
	typedef logic [15:0] tcw_cnt_t;
endpackage

// File: rtl/tcw_top.sv
/*
 One 16-bit timer channel: waveform actions, capture loads, status flags.
 Assumes synchronous line and external clock inputs and a register port
 whose strobes last one cycle; the counter steps once per core clock.
*/
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/100ps
`include "tcw_regs.svh"

module tcw_top (
	// Clock and reset
	input  wire logic        i_core_clk,
	input  wire logic        i_resetn,
	// Register port
	input  wire logic [7:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [31:0] o_rdata,
	// Timer lines
	input  wire logic        i_line_a,
	output logic             o_line_a,
	output logic             o_line_a_oe,
	input  wire logic        i_line_b,
	output logic             o_line_b,
	output logic             o_line_b_oe,
	// External clocks
	input  wire logic        i_ext_clock_0,
	input  wire logic        i_ext_clock_1,
	input  wire logic        i_ext_clock_2
);

	logic                rst_meta_reg;
	logic                rst_n;
	logic [31:0]         mode_reg;
	tcw_pkg::tcw_cnt_t   cnt_reg;
	tcw_pkg::tcw_cnt_t   ra_reg;
	tcw_pkg::tcw_cnt_t   rb_reg;
	tcw_pkg::tcw_cnt_t   rc_reg;
	tcw_pkg::tcw_dir_t   dir_reg;
	logic [7:0]          flag_reg;
	logic [7:0]          flag_set;
	logic                clk_en_reg;
	logic                run_reg;
	logic                evt_prev_reg;
	logic                ain_prev_reg;
	logic                a_unread_reg;
	logic                b_unread_reg;
	logic                line_a_reg;
	logic                line_b_reg;
	logic                oe_a_reg;
	logic                oe_b_reg;
	logic [31:0]         rdata_reg;
	logic [31:0]         rd_val;
	logic                wave;
	logic                b_out;
	logic                active;
	logic                a_hit;
	logic                b_hit;
	logic                c_hit;
	logic                evt_sig;
	logic                evt_hit;
	logic                sw_trg;
	logic                cmd_en;
	logic                cmd_dis;
	logic                trig;
	logic                ovf;
	logic                ld_a;
	logic                ld_b;
	logic                sr_rd;
	logic [1:0]          edge_sel;
	logic [1:0]          src_sel;
	logic [1:0]          shape;
	tcw_pkg::tcw_cnt_t   top;

	// Release reset through two flops; the first feeds only the second
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rst_meta_reg <= 1'b0;
			rst_n        <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n        <= rst_meta_reg;
		end
	end

	function automatic logic line_act(input logic [1:0] a,
		input logic cur);
		case (a)
			2'b01:   line_act = 1'b1;
			2'b10:   line_act = 1'b0;
			2'b11:   line_act = ~cur;
			default: line_act = cur;
		endcase
	endfunction

	assign wave     = mode_reg[`TCW_M_WAVE];
	assign edge_sel = mode_reg[`TCW_M_EDGE +: 2];
	assign src_sel  = mode_reg[`TCW_M_SRC +: 2];
	assign shape    = mode_reg[`TCW_M_SHAPE +: 2];
	assign b_out    = wave && (src_sel != 2'b00);
	assign active   = clk_en_reg && run_reg;
	assign a_hit    = active && (cnt_reg == ra_reg);
	assign b_hit    = active && (cnt_reg == rb_reg);
	assign c_hit    = active && (cnt_reg == rc_reg);
	assign sr_rd    = i_rd && (i_addr == `TCW_OFS_SR);
	assign sw_trg   = i_wr && (i_addr == `TCW_OFS_CTRL)
		&& i_wdata[`TCW_CTRL_SWT];
	assign cmd_en   = i_wr && (i_addr == `TCW_OFS_CTRL)
		&& i_wdata[`TCW_CTRL_EN];
	assign cmd_dis  = i_wr && (i_addr == `TCW_OFS_CTRL)
		&& i_wdata[`TCW_CTRL_DIS];
	// Top of an up/down ramp: C only when the C trigger is selected
	assign top = shape[1] ? rc_reg : `TCW_CNT_MAX;

	always_comb begin
		case (src_sel)
			2'b01:   evt_sig = i_ext_clock_0;
			2'b10:   evt_sig = i_ext_clock_1;
			2'b11:   evt_sig = i_ext_clock_2;
			default: evt_sig = i_line_b;
		endcase
	end

	always_comb begin
		case (edge_sel)
			2'b01:   evt_hit = evt_sig && !evt_prev_reg;
			2'b10:   evt_hit = !evt_sig && evt_prev_reg;
			2'b11:   evt_hit = evt_sig != evt_prev_reg;
			default: evt_hit = 1'b0;
		endcase
	end

	// Up shape with C trigger restarts at C; up/down turns at C instead
	assign trig = sw_trg
		|| (evt_hit && mode_reg[`TCW_M_ENTRG])
		|| (wave && c_hit && shape == 2'b10);
	assign ovf  = active && !trig && (cnt_reg == `TCW_CNT_MAX)
		&& dir_reg == tcw_pkg::TCW_UP;
	assign ld_a = !wave && i_line_a && !ain_prev_reg;
	assign ld_b = !wave && !i_line_a && ain_prev_reg;

	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			evt_prev_reg <= 1'b0;
			ain_prev_reg <= 1'b0;
		end else begin
			evt_prev_reg <= evt_sig;
			ain_prev_reg <= i_line_a;
		end
	end

	// Counter and direction
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= 16'h0000;
			dir_reg <= tcw_pkg::TCW_UP;
		end else if (trig) begin
			cnt_reg <= 16'h0000;
			dir_reg <= tcw_pkg::TCW_UP;
		end else if (active) begin
			case (dir_reg)
				tcw_pkg::TCW_UP: begin
					if (wave && shape[0] && cnt_reg == top) begin
						dir_reg <= tcw_pkg::TCW_DOWN;
						cnt_reg <= cnt_reg - 16'h0001;
					end else begin
						cnt_reg <= cnt_reg + 16'h0001;
					end
				end
				tcw_pkg::TCW_DOWN: begin
					if (!shape[0] || cnt_reg == 16'h0000) begin
						dir_reg <= tcw_pkg::TCW_UP;
						cnt_reg <= cnt_reg + 16'h0001;
					end else begin
						cnt_reg <= cnt_reg - 16'h0001;
					end
				end
				default: dir_reg <= tcw_pkg::TCW_UP;
			endcase
		end
	end

	// Clock enable and run state; a stop or disable beats a C trigger
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			clk_en_reg <= 1'b0;
			run_reg    <= 1'b0;
		end else begin
			if (cmd_en && !cmd_dis)
				clk_en_reg <= 1'b1;
			if (cmd_dis || (wave && c_hit && mode_reg[`TCW_M_DIS]))
				clk_en_reg <= 1'b0;
			if (trig)
				run_reg <= 1'b1;
			if (wave && c_hit && mode_reg[`TCW_M_STOP])
				run_reg <= 1'b0;
		end
	end

	// Mode and compare registers
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_reg <= `TCW_MODE_RST;
			ra_reg   <= 16'h0000;
			rb_reg   <= 16'h0000;
			rc_reg   <= 16'h0000;
		end else begin
			if (i_wr && i_addr == `TCW_OFS_MODE)
				mode_reg <= i_wdata;
			if (ld_a)
				ra_reg <= cnt_reg;
			else if (wave && i_wr && i_addr == `TCW_OFS_RA)
				ra_reg <= i_wdata[15:0];
			if (ld_b)
				rb_reg <= cnt_reg;
			else if (wave && i_wr && i_addr == `TCW_OFS_RB)
				rb_reg <= i_wdata[15:0];
			if (i_wr && i_addr == `TCW_OFS_RC)
				rc_reg <= i_wdata[15:0];
		end
	end

	// Unread capture tracking for overrun
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			a_unread_reg <= 1'b0;
			b_unread_reg <= 1'b0;
		end else begin
			if (ld_a)
				a_unread_reg <= 1'b1;
			else if (i_rd && i_addr == `TCW_OFS_RA)
				a_unread_reg <= 1'b0;
			if (ld_b)
				b_unread_reg <= 1'b1;
			else if (i_rd && i_addr == `TCW_OFS_RB)
				b_unread_reg <= 1'b0;
		end
	end

	always_comb begin
		flag_set    = 8'h00;
		flag_set[0] = ovf;
		flag_set[1] = (ld_a && a_unread_reg) || (ld_b && b_unread_reg);
		flag_set[2] = wave && a_hit;
		flag_set[3] = b_out && b_hit;
		flag_set[4] = c_hit;
		flag_set[5] = ld_a;
		flag_set[6] = ld_b;
		flag_set[7] = evt_hit;
	end

	// A new event in the clearing cycle survives the read
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n)
			flag_reg <= 8'h00;
		else if (sr_rd)
			flag_reg <= flag_set;
		else
			flag_reg <= flag_reg | flag_set;
	end

	// Lines: soft trigger over event over C match over A or B match
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			line_a_reg <= 1'b0;
			line_b_reg <= 1'b0;
			oe_a_reg   <= 1'b0;
			oe_b_reg   <= 1'b0;
		end else begin
			oe_a_reg <= wave;
			oe_b_reg <= b_out;
			if (wave) begin
				if (sw_trg)
					line_a_reg <= line_act(
						mode_reg[`TCW_M_A_SW +: 2], line_a_reg);
				else if (evt_hit)
					line_a_reg <= line_act(
						mode_reg[`TCW_M_A_EV +: 2], line_a_reg);
				else if (c_hit)
					line_a_reg <= line_act(
						mode_reg[`TCW_M_A_CM +: 2], line_a_reg);
				else if (a_hit)
					line_a_reg <= line_act(
						mode_reg[`TCW_M_A_AM +: 2], line_a_reg);
			end
			if (b_out) begin
				if (sw_trg)
					line_b_reg <= line_act(
						mode_reg[`TCW_M_B_SW +: 2], line_b_reg);
				else if (evt_hit)
					line_b_reg <= line_act(
						mode_reg[`TCW_M_B_EV +: 2], line_b_reg);
				else if (c_hit)
					line_b_reg <= line_act(
						mode_reg[`TCW_M_B_CM +: 2], line_b_reg);
				else if (b_hit)
					line_b_reg <= line_act(
						mode_reg[`TCW_M_B_BM +: 2], line_b_reg);
			end
		end
	end

	always_comb begin
		rd_val = 32'h0000_0000;
		if (i_addr == `TCW_OFS_MODE) begin
			rd_val = mode_reg;
		end else if (i_addr == `TCW_OFS_CV) begin
			rd_val[15:0] = cnt_reg;
		end else if (i_addr == `TCW_OFS_RA) begin
			rd_val[15:0] = ra_reg;
		end else if (i_addr == `TCW_OFS_RB) begin
			rd_val[15:0] = rb_reg;
		end else if (i_addr == `TCW_OFS_RC) begin
			rd_val[15:0] = rc_reg;
		end else if (i_addr == `TCW_OFS_SR) begin
			rd_val[7:0] = flag_reg
				& (wave ? 8'h9d : 8'h73);
			rd_val[`TCW_SR_CLKON] = clk_en_reg;
			rd_val[`TCW_SR_MIR_A] = wave ? line_a_reg : i_line_a;
			rd_val[`TCW_SR_MIR_B] = b_out ? line_b_reg : i_line_b;
		end
	end

	// Read data stand for exactly one cycle
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n)
			rdata_reg <= 32'h0000_0000;
		else if (i_rd)
			rdata_reg <= rd_val;
		else
			rdata_reg <= 32'h0000_0000;
	end

	assign o_rdata     = rdata_reg;
	assign o_line_a    = line_a_reg;
	assign o_line_a_oe = oe_a_reg;
	assign o_line_b    = line_b_reg;
	assign o_line_b_oe = oe_b_reg;

	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!rst_n);

	property p_stop;
		wave && c_hit && mode_reg[`TCW_M_STOP] |=> !run_reg;
	endproperty
	a_stop: assert property (p_stop) else $error("stop on C failed");

	property p_dis;
		wave && c_hit && mode_reg[`TCW_M_DIS] |=> !clk_en_reg;
	endproperty
	a_dis: assert property (p_dis) else $error("disable on C failed");

	property p_evt;
		evt_hit && mode_reg[`TCW_M_ENTRG] && !(wave && c_hit
			&& mode_reg[`TCW_M_STOP]) |=> cnt_reg == 16'h0000 && run_reg;
	endproperty
	a_evt: assert property (p_evt) else $error("event trigger failed");

	property p_bin;
		src_sel == 2'b00 |=> !o_line_b_oe;
	endproperty
	a_bin: assert property (p_bin) else $error("line B driven as input");

	property p_cv;
		i_rd && i_addr == `TCW_OFS_CV |=>
			o_rdata == {16'h0000, $past(cnt_reg)};
	endproperty
	a_cv: assert property (p_cv) else $error("counter read wrong");

	property p_ovf;
		ovf |=> flag_reg[0];
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow flag lost");

	property p_clr;
		sr_rd && flag_set[4] == 1'b0 |=> !flag_reg[4];
	endproperty
	a_clr: assert property (p_clr) else $error("C flag not cleared");

	property p_clkon;
		sr_rd |=> o_rdata[`TCW_SR_CLKON] == $past(clk_en_reg);
	endproperty
	a_clkon: assert property (p_clkon) else $error("clock status");

	property p_ra_ro;
		!wave && !ld_a && i_wr && i_addr == `TCW_OFS_RA |=> $stable(ra_reg);
	endproperty
	a_ra_ro: assert property (p_ra_ro) else $error("RA written");

	c_turn: cover property (dir_reg == tcw_pkg::TCW_UP
		##1 dir_reg == tcw_pkg::TCW_DOWN);
	c_stop: cover property (wave && c_hit && mode_reg[`TCW_M_STOP]);
	c_ovr:  cover property (flag_set[1]);
	c_evt:  cover property (evt_hit && mode_reg[`TCW_M_ENTRG]);

endmodule

// File: tb/tcw_line_model.sv
/*
 Far side of the timer lines: pin levels and external event clocks.
 Assumes the bench commands levels; a device enable wins its pin.
*/
`timescale 1ns/100ps
module tcw_line_model (
	// Clock
	input  wire logic       i_clk,
	// Levels commanded by the bench
	input  wire logic       i_pin_a,
	input  wire logic       i_pin_b,
	input  wire logic [2:0] i_ev,
	// Device side of the lines
	input  wire logic       i_drv_a,
	input  wire logic       i_oe_a,
	input  wire logic       i_drv_b,
	input  wire logic       i_oe_b,
	output logic            o_line_a,
	output logic            o_line_b,
	output logic [2:0]      o_ext
);
	assign o_line_a = i_oe_a ? i_drv_a : i_pin_a;
	assign o_line_b = i_oe_b ? i_drv_b : i_pin_b;
	// Registered so event clocks only move just after an edge
	always_ff @(posedge i_clk) begin
		o_ext <= i_ev;
	end
endmodule

// File: tb/tb_top.sv
/*
 Bench of the timer channel: register tasks, line and event scenarios.
 Assumes the line model on the far side and the register map header.
*/
`timescale 1ns/100ps
`include "tcw_regs.svh"
module tb_top;
	logic        clk;
	logic        rst_n;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic        wr;
	logic        rd;
	logic [31:0] rdata;
	logic        drv_a, oe_a, drv_b, oe_b, line_a, line_b, pin_a, pin_b, la;
	logic [2:0]  ev, ext;
	logic [31:0] d, d2;
	int          fails = 0;
	int          total_checks = 0;
	int          cycles = 0;

	tcw_top dut_u (
		.i_core_clk(clk), .i_resetn(rst_n), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
		.i_line_a(line_a), .o_line_a(drv_a), .o_line_a_oe(oe_a),
		.i_line_b(line_b), .o_line_b(drv_b), .o_line_b_oe(oe_b),
		.i_ext_clock_0(ext[0]), .i_ext_clock_1(ext[1]),
		.i_ext_clock_2(ext[2]));

	tcw_line_model lm_u (
		.i_clk(clk), .i_pin_a(pin_a), .i_pin_b(pin_b), .i_ev(ev),
		.i_drv_a(drv_a), .i_oe_a(oe_a), .i_drv_b(drv_b), .i_oe_b(oe_b),
		.o_line_a(line_a), .o_line_b(line_b), .o_ext(ext));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// Longest scenario is the overflow run of about 66k cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 80000) begin
			fails++;
			finish_test();
		end
	end

	task automatic wreg(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rreg(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		v = rdata;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string m);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t %s: got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		rst_n = 1'b0;
		addr = 8'h00;
		wdata = 32'h0;
		wr = 1'b0;
		rd = 1'b0;
		pin_a = 1'b0;
		pin_b = 1'b0;
		ev = 3'h0;
		la = 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rreg(`TCW_OFS_MODE, d);
		chk(d, 32'h0, "mode reset");
		rreg(`TCW_OFS_SR, d);
		chk(d, 32'h0, "status reset");
		rreg(8'h3c, d);
		chk(d, 32'h0, "unmapped");
		// Capture mode: A is read-only, loads come from line A edges
		wreg(`TCW_OFS_RA, 32'h0000_1234);
		rreg(`TCW_OFS_RA, d);
		chk(d, 32'h0, "ra locked");
		wreg(`TCW_OFS_RC, 32'h0000_0020);
		rreg(`TCW_OFS_RC, d);
		chk(d, 32'h20, "rc");
		@(posedge clk);
		pin_a <= 1'b1;
		repeat (4) @(posedge clk);
		rreg(`TCW_OFS_SR, d);
		chk(d & 32'h0002_007f, 32'h0002_0020, "a load");
		pin_a <= 1'b0;
		repeat (4) @(posedge clk);
		pin_a <= 1'b1;
		repeat (4) @(posedge clk);
		rreg(`TCW_OFS_SR, d);
		chk(d & 32'h23, 32'h22, "overrun");
		@(posedge clk);
		pin_a <= 1'b0;
		// Soft trigger actions: set, clear, toggle on both lines
		for (int e = 1; e < 4; e++) begin
			wreg(`TCW_OFS_MODE, 32'h0000_8400 | (32'(e) << `TCW_M_A_SW)
				| (32'(e) << `TCW_M_B_SW));
			wreg(`TCW_OFS_CTRL, 32'h4);
			repeat (2) @(posedge clk);
			@(negedge clk);
			la = (e == 1) ? 1'b1 : (e == 2) ? 1'b0 : ~la;
			chk({oe_a, drv_a, oe_b, drv_b}, {1'b1, la, 1'b1, la},
				"soft");
			rreg(`TCW_OFS_SR, d);
			chk(d[18:17], {la, la}, "mirror");
		end
		wreg(`TCW_OFS_RA, 32'h0000_00aa);
		wreg(`TCW_OFS_RB, 32'h0000_00bb);
		rreg(`TCW_OFS_RA, d);
		rreg(`TCW_OFS_RB, d2);
		chk({d[15:0], d2[15:0]}, 32'h00aa_00bb, "ra rb");
		wreg(`TCW_OFS_MODE, 32'h0000_8000 | (32'h3 << `TCW_M_B_SW));
		wreg(`TCW_OFS_CTRL, 32'h4);
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk({oe_a, oe_b}, 2'b10, "b as input");
		// Every event source and edge, toggling line A
		// Source 0 takes line B from its pin, the others an external clock
		for (int s = 0; s < 4; s++) begin
			for (int g = 0; g < 4; g++) begin
				wreg(`TCW_OFS_MODE, 32'h0000_8000 | (32'(s) << `TCW_M_SRC)
					| (32'(g) << `TCW_M_EDGE) | (32'h3 << `TCW_M_A_EV));
				rreg(`TCW_OFS_SR, d);
				@(posedge clk);
				if (s == 0) pin_b <= 1'b1;
				else ev[s - 1] <= 1'b1;
				repeat (4) @(posedge clk);
				if (s == 0) pin_b <= 1'b0;
				else ev[s - 1] <= 1'b0;
				repeat (4) @(posedge clk);
				rreg(`TCW_OFS_SR, d);
				chk(d & 32'h80, {24'h0, g != 0, 7'h0}, "event");
				if (g == 1 || g == 2) la = ~la;
				chk(32'(drv_a), 32'(la), "event on a");
			end
		end
		wreg(`TCW_OFS_MODE, 32'h0000_8040);
		wreg(`TCW_OFS_CTRL, 32'h5);
		repeat (60) @(posedge clk);
		rreg(`TCW_OFS_CV, d);
		rreg(`TCW_OFS_CV, d2);
		chk(d2, d, "stop at c");
		rreg(`TCW_OFS_SR, d);
		chk(d & 32'h0001_0010, 32'h0001_0010, "c flag");
		rreg(`TCW_OFS_SR, d);
		chk(d & 32'h10, 32'h0, "c cleared");
		// Stopped but enabled: the count holds until an event restarts it
		wreg(`TCW_OFS_MODE, 32'h0000_9500);
		wreg(`TCW_OFS_CTRL, 32'h1);
		rreg(`TCW_OFS_CV, d);
		rreg(`TCW_OFS_CV, d2);
		chk(d2, d, "held");
		ev[0] <= 1'b1;
		repeat (4) @(posedge clk);
		ev[0] <= 1'b0;
		rreg(`TCW_OFS_CV, d);
		rreg(`TCW_OFS_CV, d2);
		chk(d2 - d, 32'h2, "steps");
		wreg(`TCW_OFS_MODE, 32'h0000_8080);
		wreg(`TCW_OFS_CTRL, 32'h5);
		repeat (60) @(posedge clk);
		rreg(`TCW_OFS_SR, d);
		chk(d & 32'h0001_0000, 32'h0, "disable at c");
		// Shape with C trigger never passes C
		wreg(`TCW_OFS_MODE, 32'h0000_c000);
		wreg(`TCW_OFS_CTRL, 32'h5);
		repeat (100) @(posedge clk);
		rreg(`TCW_OFS_CV, d);
		chk(32'(d > 32'h20), 32'h0, "c trigger");
		// Full wrap: overflow and A, B, C matches; B must be an output
		wreg(`TCW_OFS_MODE, 32'h0000_8400);
		wreg(`TCW_OFS_CTRL, 32'h5);
		rreg(`TCW_OFS_SR, d);
		repeat (65540) @(posedge clk);
		rreg(`TCW_OFS_SR, d);
		chk(d & 32'h1f, 32'h1d, "wrap");
		finish_test();
	end
endmodule
